// ### inc/rfp_pkg.sv
package rfp_pkg;

  // Clock and bit timing.
  localparam int unsigned CLK_HZ = 32'h0262_5A00;
  localparam int unsigned BIT_RATE_BPS = 32'h0000_12C0;
  localparam int unsigned MS_PER_S = 32'h0000_03E8;
  localparam int unsigned TONE_HZ = 32'h0000_08CA;
  localparam int unsigned CYC_PER_BIT = CLK_HZ / BIT_RATE_BPS;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (TONE_HZ << 1);
  localparam int unsigned DIV_W = 16;

  // Phase lengths in milliseconds.
  localparam logic [5:0] LEAD_MIN_MS = 6'h14;
  localparam logic [5:0] LEAD_MAX_MS = 6'h3C;
  localparam logic [5:0] TONE_MS = 6'h0F;
  localparam logic [5:0] TAIL_MS = 6'h05;

  // Preamble words and their last bit indices.
  localparam logic [47:0] SYNC_WORD = 48'hEB90_B433_AAAA;
  localparam logic [31:0] MARK_WORD = 32'h352E_F853;
  localparam logic [5:0] SYNC_LAST = 6'h2F;
  localparam logic [5:0] MARK_LAST = 6'h1F;
  localparam logic [5:0] BYTE_LAST = 6'h07;
  localparam logic [5:0] CNT_ONE = 6'h01;

  // Link header layout.
  localparam logic [1:0] HDR_VERSION = 2'h0;
  localparam logic [3:0] HDR_RESERVED = 4'h0;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LEAD = 7'h02,
    ST_TONE = 7'h04,
    ST_SYNC = 7'h08,
    ST_MARK = 7'h10,
    ST_PAY = 7'h20,
    ST_TAIL = 7'h40
  } rfp_state_t;

endpackage

// ### hw/rfp_tick_div.sv
`timescale 1ns/1ps
module rfp_tick_div
  import rfp_pkg::*;
#(
  parameter int unsigned DIV = 32'h0000_0002
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  output logic tick_out
);

  localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);
  localparam logic [DIV_W-1:0] FIRST = DIV_W'(1);

  logic [DIV_W-1:0] cnt_q;

  wire at_last = (cnt_q == LAST);

  // A restart counts its own cycle, so the first tick after it comes exactly
  // DIV cycles later, as every following one does.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      cnt_q <= FIRST;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= at_last ? '0 : cnt_q + 1'b1;
      tick_out <= at_last;
    end
  end

endmodule

// ### hw/rfp_tone_gen.sv
`timescale 1ns/1ps
module rfp_tone_gen
  import rfp_pkg::*;
#(
  parameter int unsigned HALF_CYC = TONE_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  output logic tone_out
);

  localparam logic [DIV_W-1:0] LAST = DIV_W'(HALF_CYC - 1);

  logic [DIV_W-1:0] cnt_q;

  wire flip = (cnt_q == LAST);

  // Square wave; silent whenever the tone phase was not active in the cycle before.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !enable_in) begin
      cnt_q <= '0;
      tone_out <= 1'b0;
    end else begin
      cnt_q <= flip ? '0 : cnt_q + 1'b1;
      tone_out <= tone_out ^ flip;
    end
  end

  property p_tone_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      enable_in |=> !enable_in || (tone_out != $past(tone_out)) == $past(flip);
  endproperty
  a_tone_hold: assert property (p_tone_hold)
    else $error("tone toggled off its half period");

endmodule

// ### hw/rfp_frame_tx.sv
`timescale 1ns/1ps
module rfp_frame_tx
  import rfp_pkg::*;
#(
  parameter int unsigned CYC_BIT = CYC_PER_BIT,
  parameter int unsigned CYC_MS = CYC_PER_MS,
  parameter int unsigned TONE_HALF = TONE_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [5:0] lead_ms_in,
  input wire logic [9:0] payload_byte_count_in,
  input wire logic pay_valid_in,
  input wire logic [7:0] pay_data_in,
  input wire logic pay_last_in,
  output logic pay_ready_out,
  output logic [15:0] hdr_out,
  output logic transmit_key_out,
  output logic tone_out,
  output logic data_out,
  output logic data_en_out,
  output logic busy_out,
  output logic refused_out,
  output logic underrun_out
);

  rfp_state_t state_q;
  rfp_state_t state_d;
  logic [5:0] ms_q;
  logic [5:0] lead_len_q;
  logic [5:0] cnt_q;
  logic [47:0] sh_q;
  logic [7:0] hold_q;
  logic hold_v_q;
  logic hold_last_q;
  logic cur_last_q;
  logic got_last_q;
  logic data_q;
  logic data_en_q;
  logic key_q;
  logic busy_q;
  logic ready_q;
  logic refused_q;
  logic underrun_q;
  logic [15:0] hdr_q;
  logic ms_tick;
  logic bit_tick;

  wire st_idle = (state_q == ST_IDLE);
  wire st_lead = (state_q == ST_LEAD);
  wire st_tone = (state_q == ST_TONE);
  wire st_sync = (state_q == ST_SYNC);
  wire st_mark = (state_q == ST_MARK);
  wire st_pay = (state_q == ST_PAY);
  wire st_tail = (state_q == ST_TAIL);

  // A frame starts only on the media-access trigger, never while busy.
  wire go = start_in && st_idle;
  wire refuse = start_in && !st_idle;

  // Lead-in length is clamped into its legal range when a frame starts.
  wire [5:0] lead_clamped = (lead_ms_in < LEAD_MIN_MS) ? LEAD_MIN_MS :
                            (lead_ms_in > LEAD_MAX_MS) ? LEAD_MAX_MS :
                            lead_ms_in;

  // The tail is timed from the end of the last data bit.
  wire tail_data = st_tail && data_en_q;
  wire tail_go = tail_data && bit_tick;
  wire [5:0] ms_target = st_lead ? lead_len_q :
                         st_tone ? TONE_MS : TAIL_MS;
  wire ms_count = (st_lead || st_tone || st_tail) && !tail_data;
  wire ms_done = ms_count && ms_tick && (ms_q == ms_target - CNT_ONE);
  wire phase_change = (state_d != state_q);
  wire ms_restart = phase_change || tail_go;

  // Bit boundaries of the serial stream.
  wire shifting = st_sync || st_mark || st_pay;
  wire bit_step = shifting && bit_tick;
  wire sync_end = st_sync && bit_step && (cnt_q == SYNC_LAST);
  wire mark_end = st_mark && bit_step && (cnt_q == MARK_LAST);
  wire byte_end = st_pay && bit_step && (cnt_q == BYTE_LAST);
  wire need_byte = mark_end || byte_end;
  wire pay_end = need_byte && (cur_last_q || !hold_v_q);
  wire load_byte = need_byte && !pay_end;
  wire take = pay_valid_in && ready_q;
  wire hold_v_d = take || (hold_v_q && !load_byte);
  wire got_last_d = (got_last_q && !go) || (take && pay_last_in);
  wire ready_d = shifting && !hold_v_d && !got_last_d;
  wire busy_d = (state_d != ST_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (go) state_d = ST_LEAD;
      ST_LEAD: if (ms_done) state_d = ST_TONE;
      ST_TONE: if (ms_done) state_d = ST_SYNC;
      ST_SYNC: if (sync_end) state_d = ST_MARK;
      ST_MARK: begin
        if (mark_end) state_d = pay_end ? ST_TAIL : ST_PAY;
      end
      ST_PAY: if (pay_end) state_d = ST_TAIL;
      ST_TAIL: if (ms_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  rfp_tick_div #(
    .DIV(CYC_MS)
  ) u_ms_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(ms_restart),
    .tick_out(ms_tick)
  );

  // Restarted as the first bit goes out so that bit periods stay even.
  rfp_tick_div #(
    .DIV(CYC_BIT)
  ) u_bit_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(st_tone && ms_done),
    .tick_out(bit_tick)
  );

  rfp_tone_gen #(
    .HALF_CYC(TONE_HALF)
  ) u_tone (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(st_tone),
    .tone_out(tone_out)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      ms_q <= '0;
    end else begin
      state_q <= state_d;
      ms_q <= ms_restart ? '0 : ms_q + (ms_count && ms_tick ? 6'h01 : 6'h00);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lead_len_q <= LEAD_MIN_MS;
      hdr_q <= '0;
    end else if (go) begin
      lead_len_q <= lead_clamped;
      hdr_q <= {HDR_VERSION, HDR_RESERVED, payload_byte_count_in};
    end
  end

  // Serializer: correlation word, marker, then payload bytes with no gap.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sh_q <= '0;
      cnt_q <= '0;
      data_q <= 1'b0;
      data_en_q <= 1'b0;
    end else if (st_tone && ms_done) begin
      sh_q <= SYNC_WORD << 1;
      data_q <= SYNC_WORD[47];
      cnt_q <= CNT_ONE;
      data_en_q <= 1'b1;
    end else if (bit_step) begin
      data_q <= sh_q[47];
      if (sync_end) begin
        sh_q <= {MARK_WORD, 16'h0000};
        cnt_q <= '0;
      end else if (need_byte) begin
        sh_q <= {hold_q, 40'h00_0000_0000};
        cnt_q <= '0;
      end else begin
        sh_q <= sh_q << 1;
        cnt_q <= cnt_q + CNT_ONE;
      end
    end else if (tail_go) begin
      data_q <= 1'b0;
      data_en_q <= 1'b0;
    end
  end

  // One-byte holding stage filled ahead of each byte boundary.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hold_q <= '0;
      hold_v_q <= 1'b0;
      hold_last_q <= 1'b0;
      cur_last_q <= 1'b0;
      got_last_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      if (take) begin
        hold_q <= pay_data_in;
        hold_last_q <= pay_last_in;
      end
      if (load_byte) begin
        cur_last_q <= hold_last_q;
      end else if (go) begin
        cur_last_q <= 1'b0;
      end
      hold_v_q <= hold_v_d && !go;
      got_last_q <= got_last_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      key_q <= 1'b0;
      busy_q <= 1'b0;
      refused_q <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      key_q <= busy_d;
      busy_q <= busy_d;
      refused_q <= refuse;
      underrun_q <= pay_end && !cur_last_q;
    end
  end

  assign pay_ready_out = ready_q;
  assign hdr_out = hdr_q;
  assign transmit_key_out = key_q;
  assign data_out = data_q;
  assign data_en_out = data_en_q;
  assign busy_out = busy_q;
  assign refused_out = refused_q;
  assign underrun_out = underrun_q;

  property p_refuse;
    @(posedge clk_in) disable iff (!rst_n_in)
      start_in && !st_idle && !(st_tail && ms_done) |=>
        refused_out && !st_idle;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("start while busy was not refused");

  property p_lead_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_lead && ms_done |-> ms_q + CNT_ONE >= LEAD_MIN_MS
        && ms_q < LEAD_MAX_MS && !data_en_q && !tone_out;
  endproperty
  a_lead_len: assert property (p_lead_len)
    else $error("carrier lead-in length out of range");

  property p_lead_cfg;
    @(posedge clk_in) disable iff (!rst_n_in)
      go |=> lead_len_q == $past(lead_clamped);
  endproperty
  a_lead_cfg: assert property (p_lead_cfg)
    else $error("lead-in setting not captured");

  property p_tone_end;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_tone && ms_tick |-> (ms_q == TONE_MS - CNT_ONE) == (state_d == ST_SYNC);
  endproperty
  a_tone_end: assert property (p_tone_end)
    else $error("tone phase length wrong");

  property p_sync_load;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_tone && ms_done |=> st_sync && data_en_out
        && data_out == SYNC_WORD[47] && sh_q == (SYNC_WORD << 1);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("correlation word not loaded");

  property p_mark_load;
    @(posedge clk_in) disable iff (!rst_n_in)
      sync_end |=> st_mark && sh_q[47:16] == MARK_WORD;
  endproperty
  a_mark_load: assert property (p_mark_load)
    else $error("frame marker not loaded after correlation word");

  property p_msb_first;
    @(posedge clk_in) disable iff (!rst_n_in)
      bit_step |=> data_out == $past(sh_q[47]) && data_en_out;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("serial bit not taken from the top of the shifter");

  property p_pay_follow;
    @(posedge clk_in) disable iff (!rst_n_in)
      mark_end && hold_v_q |=> st_pay && cnt_q == 6'h00
        && sh_q[47:40] == $past(hold_q);
  endproperty
  a_pay_follow: assert property (p_pay_follow)
    else $error("payload did not follow the marker");

  property p_bit_space;
    @(posedge clk_in) disable iff (!rst_n_in)
      bit_tick |=> !bit_tick[*7];
  endproperty
  a_bit_space: assert property (p_bit_space)
    else $error("bit ticks too close");

  property p_key_release;
    @(posedge clk_in) disable iff (!rst_n_in)
      st_tail && ms_done |=> st_idle && !transmit_key_out && !busy_out;
  endproperty
  a_key_release: assert property (p_key_release)
    else $error("key not released after tail");

endmodule

// ### tb/rfp_radio_model.sv
`timescale 1ns/1ps
module rfp_radio_model
  import rfp_pkg::*;
#(
  parameter int unsigned CYC_BIT = 8
) (
  input wire logic clk_in,
  input wire logic key_in,
  input wire logic tone_in,
  input wire logic data_in,
  input wire logic data_en_in
);
  int cyc, t_key_on, t_key_off, t_tone, t_tog, half, tone_bad;
  int t_den_on, t_den_off, den_cyc, phase, nacc;
  logic prev_key = 1'b0;
  logic prev_den = 1'b0;
  logic prev_data = 1'b0;
  logic prev_tone = 1'b0;
  logic [31:0] hunt = 32'h0000_0000;
  logic [7:0] acc = 8'h00;
  bit locked;
  bit bits[$];
  logic [7:0] bytes[$];

  task automatic take(input logic b);
    bits.push_back(b);
    if (locked) begin
      acc = {acc[6:0], b};
      nacc++;
      if (nacc == 8) begin
        bytes.push_back(acc);
        nacc = 0;
      end
    end else begin
      hunt = {hunt[30:0], b};
      locked = (hunt === MARK_WORD);
    end
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (key_in === 1'b1 && prev_key !== 1'b1) begin
      t_key_on = cyc;
      t_tone = 0;
      t_tog = 0;
      half = 0;
      tone_bad = 0;
      locked = 0;
      nacc = 0;
      den_cyc = 0;
      bits.delete();
      bytes.delete();
    end
    if (key_in !== 1'b1 && prev_key === 1'b1) t_key_off = cyc;
    if (tone_in === 1'b1 && t_tone == 0) t_tone = cyc;
    if (tone_in !== prev_tone) begin
      if (t_tog != 0 && half == 0) half = cyc - t_tog;
      t_tog = cyc;
    end
    if (data_en_in === 1'b1 && prev_den !== 1'b1) begin
      t_den_on = cyc;
      phase = 0;
    end
    if (data_en_in !== 1'b1 && prev_den === 1'b1) t_den_off = cyc;
    if (data_en_in === 1'b1) begin
      den_cyc++;
      if (tone_in !== 1'b0) tone_bad++;
      // Resynchronise the sampling phase on every data edge.
      if (data_in !== prev_data) phase = 0;
      if (phase == CYC_BIT / 2) take(data_in);
      phase = (phase + 1) % CYC_BIT;
    end
    prev_key = key_in;
    prev_den = data_en_in;
    prev_data = data_in;
    prev_tone = tone_in;
  end
endmodule

// ### tb/rfp_frame_tx_tb.sv
`timescale 1ns/1ps
module rfp_frame_tx_tb
  import rfp_pkg::*;
;
  localparam int CB = 8;
  localparam int CM = 64;
  localparam int TH = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic pay_valid_in = 1'b0;
  logic pay_last_in = 1'b0;
  logic [5:0] lead_ms_in = 6'h14;
  logic [9:0] payload_byte_count_in = 10'h000;
  logic [7:0] pay_data_in = 8'h00;
  logic pay_ready_out, transmit_key_out, tone_out, data_out, data_en_out;
  logic busy_out, refused_out, underrun_out;
  logic [15:0] hdr_out;
  int err_count, checks;
  int und_seen;
  bit no_last;
  logic [31:0] lfsr = 32'h0000_E0EC;
  logic [7:0] feed[$];
  logic [7:0] exp_bytes[$];
  bit exp_bits[$];

  always #12.5 clk_in = ~clk_in;

  rfp_frame_tx #(.CYC_BIT(CB), .CYC_MS(CM), .TONE_HALF(TH)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .lead_ms_in(lead_ms_in), .payload_byte_count_in(payload_byte_count_in),
    .pay_valid_in(pay_valid_in), .pay_data_in(pay_data_in),
    .pay_last_in(pay_last_in), .pay_ready_out(pay_ready_out),
    .hdr_out(hdr_out), .transmit_key_out(transmit_key_out),
    .tone_out(tone_out), .data_out(data_out), .data_en_out(data_en_out),
    .busy_out(busy_out), .refused_out(refused_out),
    .underrun_out(underrun_out));

  rfp_radio_model #(.CYC_BIT(CB)) radio (
    .clk_in(clk_in), .key_in(transmit_key_out), .tone_in(tone_out),
    .data_in(data_out), .data_en_in(data_en_out));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(posedge clk_in) begin
    if (pay_valid_in && pay_ready_out === 1'b1) void'(feed.pop_front());
    #2;
    pay_valid_in = feed.size() > 0;
    pay_data_in = feed.size() > 0 ? feed[0] : 8'h00;
    pay_last_in = feed.size() == 1 && !no_last;
  end

  always @(posedge clk_in) if (underrun_out === 1'b1) und_seen++;

  task automatic check(input bit ok, input string what);
    checks++;
    if (!ok) begin
      err_count++;
      $display("BAD at %0t: %s", $time, what);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic run_frame(input logic [5:0] lead, input int ld, input int n,
                           input bit cut);
    int w, lo;
    bit seen;
    exp_bits.delete();
    no_last = cut;
    und_seen = 0;
    for (int i = 47; i >= 0; i--) exp_bits.push_back(SYNC_WORD[i]);
    for (int i = 31; i >= 0; i--) exp_bits.push_back(MARK_WORD[i]);
    for (int k = 0; k < n; k++) begin
      lfsr = next_rand(lfsr);
      feed.push_back(lfsr[7:0]);
      for (int i = 7; i >= 0; i--) exp_bits.push_back(lfsr[i]);
    end
    exp_bytes = feed;
    lead_ms_in = lead;
    payload_byte_count_in = n[9:0];
    start_in = 1'b1;
    @(posedge clk_in);
    #2;
    start_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #2;
    check(busy_out === 1'b1 && transmit_key_out === 1'b1, "key");
    check(hdr_out === {6'h00, n[9:0]}, "header");
    start_in = 1'b1;
    @(posedge clk_in);
    #2;
    start_in = 1'b0;
    seen = 0;
    repeat (2) begin
      if (refused_out === 1'b1) seen = 1;
      @(posedge clk_in);
      #2;
    end
    check(seen, "no refusal while busy");
    w = 0;
    while (busy_out !== 1'b0 && w < 20000) begin
      @(posedge clk_in);
      w++;
    end
    #2;
    check(w < 20000 && transmit_key_out === 1'b0, "not idle");
    lo = (ld + 15) * CM;
    w = radio.t_den_on - radio.t_key_on;
    check(w inside {[lo - 2:lo + 2]}, "lead plus tone");
    lo = ld * CM;
    w = radio.t_tone - radio.t_key_on;
    check(w inside {[lo - 2:lo + TH + 2]}, "tone start");
    check(radio.half == TH && radio.tone_bad == 0, "tone");
    w = radio.t_key_off - radio.t_den_off;
    check(w inside {[5 * CM - 2:5 * CM + 2]}, "tail");
    lo = (80 + 8 * n) * CB;
    check(radio.den_cyc inside {[lo - 2:lo + 2]}, "bit time");
    check(radio.bits == exp_bits, "stream");
    check(radio.bytes == exp_bytes, "payload");
    check(und_seen == int'(cut), "underrun");
    $display("frame lead %0d bytes %0d done", ld, n);
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    @(posedge clk_in);
    #2;
    run_frame(6'h14, 20, 2, 1'b0);
    run_frame(6'h3C, 60, 3, 1'b0);
    run_frame(6'h3F, 60, 1, 1'b0);
    run_frame(6'h05, 20, 4, 1'b1);
    conclude();
  end

  initial begin
    #1_000_000;
    err_count++;
    conclude();
  end
endmodule
